/* rtl/power_down_oscillator_control.v */
// Power-down, idle and oscillator control with an AXI4-Lite register slave.
// Assumes one clock aclk; wfi_exec, deep_sleep_bit, src_tick come from aclk logic;
// wake_event_pin is asynchronous.
`timescale 1ns/1ps
`include "pdctl_defines.vh"
module power_down_oscillator_control #(
  parameter [12:0] DLY_XTAL_CYC = `DLY_XTAL,
  parameter [12:0] DLY_HRC_CYC  = `DLY_HRC
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        wfi_exec,
  input  wire        deep_sleep_bit,
  input  wire        cpu_irq_pending,
  input  wire        wake_event_pin,
  input  wire [1:0]  sys_src_sel,
  input  wire        src_tick,
  input  wire        wdt_src_slow_rc,
  output reg         cpu_clk_en,
  output reg         sys_clk_en,
  output reg         periph_clk_en,
  output reg         wdt_clk_en,
  output reg         flash_programmer_clock_enable,
  output reg         low_speed_rc_on,
  output reg         high_speed_rc_on,
  output reg         high_speed_crystal_on,
  output reg         low_speed_crystal_on,
  output reg         crystal_pin_in_ext_clock,
  output reg         crystal_pin_in_gpio,
  output reg         crystal_pin_out_gpio,
  output wire        wake_irq,
  output wire        irq
);
  // Operating states
  localparam [1:0] ST_RUN  = 2'h0;
  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_PDN  = 2'h2;
  localparam [1:0] ST_WDLY = 2'h3;

  reg  [9:0]        power_down_control_q;
  reg  [2:0]        system_bus_clock_gate_q;
  reg  [`EVT_W-1:0] evt_sts_q;
  reg  [`EVT_W-1:0] evt_mask_q;
  reg  [1:0]        key_seq_q;
  reg               unlocked_q;
  reg  [1:0]        state_q;
  reg  [1:0]        state_d;
  reg  [5:0]        aw_idx_q;
  reg               aw_have_q;
  reg  [31:0]       wd_q;
  reg  [3:0]        ws_q;
  reg               w_have_q;
  reg               wake_lvl_q;
  reg  [31:0]       rd_d;
  reg               rd_ok;
  reg               dly_start;
  reg               wake_now;
  wire              wake_lvl;
  wire              wake_rise;
  wire              dly_done;
  wire              do_wr;
  wire [31:0]       bm;
  wire [9:0]        pm;
  wire [1:0]        xtl;
  wire              in_pdn;
  wire [12:0]       dly_limit;
  wire              wr_pwr;
  wire              wr_key;

  // ***************************************************************
  // Wake pin synchroniser and delay counter
  // ***************************************************************
  pin_sync u_wake_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (wake_event_pin),
    .level_q (wake_lvl)
  );

  // Edge detector reads only the settled level
  always @(posedge aclk) begin
    if (!aresetn) wake_lvl_q <= 1'b0;
    else wake_lvl_q <= wake_lvl;
  end
  assign wake_rise = wake_lvl & ~wake_lvl_q;

  // Crystals need a long settle, the fast RC only a short one
  assign dly_limit = (sys_src_sel == `SRC_HRC) ? DLY_HRC_CYC : DLY_XTAL_CYC;

  wake_delay_counter #(
    .W (13)
  ) u_delay (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (dly_start),
    .tick    (src_tick),
    .limit   (dly_limit),
    .busy_q  (),
    .done_q  (dly_done)
  );

  // ***************************************************************
  // Power mode sequencing
  // ***************************************************************
  // Next state; mixed sleep settings fall back to idle
  always @* begin
    state_d   = state_q;
    dly_start = 1'b0;
    wake_now  = 1'b0;
    case (state_q)
      ST_RUN: begin
        if (wfi_exec) begin
          if (deep_sleep_bit && power_down_control_q[`B_PDE])
            state_d = ST_PDN;
          else
            state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (cpu_irq_pending) state_d = ST_RUN;
      end
      ST_PDN: begin
        if (wake_rise) begin
          wake_now = 1'b1;
          // The slow RC source needs no settle time
          if (power_down_control_q[`B_WDLY] && sys_src_sel != `SRC_LRC) begin
            state_d   = ST_WDLY;
            dly_start = 1'b1;
          end else begin
            state_d = ST_RUN;
          end
        end
      end
      ST_WDLY: begin
        if (dly_done) state_d = ST_RUN;
      end
      default: state_d = ST_RUN;
    endcase
  end

  // State register
  always @(posedge aclk) begin
    if (!aresetn) state_q <= ST_RUN;
    else state_q <= state_d;
  end

  // ***************************************************************
  // AXI4-Lite slave
  // ***************************************************************
  assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_wr         = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign bm     = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
  assign pm     = bm[9:0] & `PWR_PROT_MSK;
  assign wr_pwr = do_wr && aw_idx_q == `OFS_PWR;
  assign wr_key = do_wr && aw_idx_q == `OFS_KEY && ws_q[0];

  // Address and data are latched separately, in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      aw_idx_q     <= 6'h00;
      wd_q         <= 32'h0000_0000;
      ws_q         <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wd_q     <= s_axi_wdata;
        ws_q     <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_idx_q <= `OFS_KEY) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read mux; unmapped words read zero with an error
  always @* begin
    rd_d  = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr[7:2])
      `OFS_PWR:      rd_d[9:0]        = power_down_control_q;
      `OFS_BUSGATE:  rd_d[2:0]        = system_bus_clock_gate_q;
      `OFS_EVT_STS:  rd_d[`EVT_W-1:0] = evt_sts_q;
      `OFS_EVT_MASK: rd_d[`EVT_W-1:0] = evt_mask_q;
      `OFS_KEY:      rd_d[0]          = unlocked_q;
      default:       rd_ok            = 1'b0;
    endcase
  end

  // Read answer one cycle after the address
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_d;
      s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  // Key sequence; any wrong byte restarts it, writing zero relocks
  always @(posedge aclk) begin
    if (!aresetn) begin
      key_seq_q  <= 2'h0;
      unlocked_q <= 1'b0;
    end else if (wr_key) begin
      if (unlocked_q) begin
        if (wd_q[7:0] == 8'h00) unlocked_q <= 1'b0;
      end else if (key_seq_q == 2'h0 && wd_q[7:0] == `KEY1) begin
        key_seq_q <= 2'h1;
      end else if (key_seq_q == 2'h1 && wd_q[7:0] == `KEY2) begin
        key_seq_q <= 2'h2;
      end else if (key_seq_q == 2'h2 && wd_q[7:0] == `KEY3) begin
        key_seq_q  <= 2'h0;
        unlocked_q <= 1'b1;
      end else begin
        key_seq_q <= 2'h0;
      end
    end
  end

  // Power-down control: protected fields, sticky wake flag
  always @(posedge aclk) begin
    if (!aresetn) begin
      power_down_control_q <= `PWR_RST;
    end else begin
      if (wr_pwr && unlocked_q)
        power_down_control_q <= (power_down_control_q & ~pm) | (wd_q[9:0] & pm);
      // Flag clears by writing one, no key needed
      if (wr_pwr && ws_q[0] && wd_q[`B_WSTS])
        power_down_control_q[`B_WSTS] <= 1'b0;
      // Hardware set beats the software clear
      if (wake_now) begin
        power_down_control_q[`B_WSTS] <= 1'b1;
        power_down_control_q[`B_PDE]  <= 1'b0;
      end
    end
  end

  // Bus clock gate, event status and mask
  always @(posedge aclk) begin
    if (!aresetn) begin
      system_bus_clock_gate_q <= `BUSGATE_RST;
      evt_mask_q              <= {`EVT_W{1'b0}};
      evt_sts_q               <= {`EVT_W{1'b0}};
    end else begin
      if (do_wr && aw_idx_q == `OFS_BUSGATE && ws_q[0])
        system_bus_clock_gate_q <= wd_q[2:0];
      if (do_wr && aw_idx_q == `OFS_EVT_MASK && ws_q[0])
        evt_mask_q <= wd_q[`EVT_W-1:0];
      if (do_wr && aw_idx_q == `OFS_EVT_STS && ws_q[0])
        evt_sts_q <= evt_sts_q & ~wd_q[`EVT_W-1:0];
      // Events are applied last so a same-cycle clear loses
      if (wake_now) evt_sts_q[`EV_WAKE] <= 1'b1;
      if (dly_done) evt_sts_q[`EV_DONE] <= 1'b1;
      if (wr_pwr && !unlocked_q && |pm) evt_sts_q[`EV_REFUSED] <= 1'b1;
    end
  end

  // ***************************************************************
  // Clock gates and oscillator enables
  // ***************************************************************
  assign xtl    = power_down_control_q[1:0];
  assign in_pdn = (state_d == ST_PDN);

  // Registered gates follow the next state, so they switch with it
  always @(posedge aclk) begin
    if (!aresetn) begin
      cpu_clk_en                    <= 1'b1;
      sys_clk_en                    <= 1'b1;
      periph_clk_en                 <= 1'b1;
      wdt_clk_en                    <= 1'b1;
      flash_programmer_clock_enable <= 1'b1;
      low_speed_rc_on               <= 1'b1;
      high_speed_rc_on              <= 1'b1;
      high_speed_crystal_on         <= 1'b0;
      low_speed_crystal_on          <= 1'b0;
      crystal_pin_in_ext_clock      <= 1'b0;
      crystal_pin_in_gpio           <= 1'b1;
      crystal_pin_out_gpio          <= 1'b1;
    end else begin
      cpu_clk_en    <= (state_d == ST_RUN);
      sys_clk_en    <= (state_d == ST_RUN) || (state_d == ST_IDLE);
      periph_clk_en <= !in_pdn && !(state_d == ST_WDLY);
      wdt_clk_en    <= (!in_pdn && !(state_d == ST_WDLY)) || wdt_src_slow_rc;
      flash_programmer_clock_enable <= system_bus_clock_gate_q[`B_FLASH] &&
                                       ((state_d == ST_RUN) || (state_d == ST_IDLE));
      // The slow RC is never stopped by power-down
      low_speed_rc_on       <= power_down_control_q[`B_LRC];
      high_speed_rc_on      <= power_down_control_q[`B_HRC] && !in_pdn;
      high_speed_crystal_on <= (xtl == `XTL_FAST) && !in_pdn;
      low_speed_crystal_on  <= (xtl == `XTL_SLOW) &&
                               (!in_pdn || power_down_control_q[`B_KEEPLX]);
      crystal_pin_in_ext_clock <= (xtl == `XTL_EXTCLK);
      crystal_pin_in_gpio      <= (xtl == `XTL_GPIO);
      crystal_pin_out_gpio     <= (xtl == `XTL_GPIO) || (xtl == `XTL_EXTCLK);
    end
  end

  // ***************************************************************
  // Interrupts
  // ***************************************************************
  // Combinational so clearing either bit drops the request at once
  assign wake_irq = power_down_control_q[`B_WSTS] & power_down_control_q[`B_WIE];
  assign irq      = |(evt_sts_q & evt_mask_q);
endmodule // power_down_oscillator_control

/* rtl/pdctl_defines.vh */
// Offsets, field positions, reset values and counts of the power-down control block.
// Assumes inclusion by bare name from each design file; definitions only.
`ifndef PDCTL_DEFINES_VH
`define PDCTL_DEFINES_VH
// Register word indices, byte address over four
`define OFS_PWR      6'h00
`define OFS_BUSGATE  6'h01
`define OFS_EVT_STS  6'h02
`define OFS_EVT_MASK 6'h03
`define OFS_KEY      6'h04
// Reset values and writable masks
`define PWR_RST      10'h01C
`define PWR_PROT_MSK 10'h2BF
`define BUSGATE_RST  3'h5
// Field positions
`define B_PDE        7
`define B_WSTS       6
`define B_WIE        5
`define B_WDLY       4
`define B_LRC        3
`define B_HRC        2
`define B_KEEPLX     9
`define B_FLASH      2
// Crystal mode encodings
`define XTL_GPIO     2'h0
`define XTL_FAST     2'h1
`define XTL_SLOW     2'h2
`define XTL_EXTCLK   2'h3
// System clock source codes
`define SRC_HRC      2'h0
`define SRC_LRC      2'h3
// Protection key sequence
`define KEY1         8'h59
`define KEY2         8'h16
`define KEY3         8'h88
// Wake-up delay in cycles of the selected source
`define DLY_XTAL     13'h1000
`define DLY_HRC      13'h010
// Bus responses and event bits
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`define EV_WAKE      0
`define EV_DONE      1
`define EV_REFUSED   2
`define EVT_W        3
`endif

/* rtl/pin_sync.v */
// Three-stage synchroniser for one asynchronous pin.
// Assumes a single clock aclk; output changes once stages two and three agree.
`timescale 1ns/1ps
module pin_sync (
  input  wire aclk,
  input  wire aresetn,
  input  wire pin,
  output reg  level_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // First stage feeds only the second
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) level_q <= s3_q; // Accept only a settled value
    end
  end
endmodule // pin_sync

/* rtl/wake_delay_counter.v */
// Post-wake stabilisation counter, counting ticks of the selected source.
// Assumes tick is a one-cycle enable pulse on aclk from the source divider.
`timescale 1ns/1ps
module wake_delay_counter #(
  parameter W = 13
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire         start,
  input  wire         tick,
  input  wire [W-1:0] limit,
  output reg          busy_q,
  output reg          done_q
);
  reg [W-1:0] cnt_q;

  // Count source ticks up to the terminal value
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q  <= {W{1'b0}};
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        cnt_q  <= {W{1'b0}};
        busy_q <= 1'b1;
      end else if (busy_q && tick) begin
        if (cnt_q == limit - 1'b1) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end
endmodule // wake_delay_counter

/* dv/pdctl_asserts.sv */
// Checker on the top ports: bus handshakes, clock gating and crystal pin modes.
// Assumes binding into power_down_oscillator_control; one clock domain, aresetn active low.
`timescale 1ns/1ps
module pdctl_asserts (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        wfi_exec,
  input wire        deep_sleep_bit,
  input wire        cpu_irq_pending,
  input wire        wdt_src_slow_rc,
  input wire        cpu_clk_en,
  input wire        sys_clk_en,
  input wire        periph_clk_en,
  input wire        wdt_clk_en,
  input wire        flash_programmer_clock_enable,
  input wire        low_speed_rc_on,
  input wire        high_speed_rc_on,
  input wire        high_speed_crystal_on,
  input wire        low_speed_crystal_on,
  input wire        crystal_pin_in_ext_clock,
  input wire        crystal_pin_in_gpio,
  input wire        crystal_pin_out_gpio,
  input wire        wake_irq
);
  // ************************************************************
  // Properties
  // ************************************************************
  // Reset is also the disable, so reset values are seen at the first live edge
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reset_values_a: assert property (
    $rose(aresetn) |-> high_speed_rc_on && low_speed_rc_on && !high_speed_crystal_on && !low_speed_crystal_on
      && crystal_pin_in_gpio && crystal_pin_out_gpio && flash_programmer_clock_enable && cpu_clk_en && !wake_irq)
    else $error("reset values wrong");
  pin_gpio_a: assert property (
    crystal_pin_in_gpio |-> !high_speed_crystal_on && !low_speed_crystal_on && !crystal_pin_in_ext_clock
      && crystal_pin_out_gpio) else $error("gpio pin mode inconsistent");
  pin_ext_a: assert property (
    crystal_pin_in_ext_clock |-> !crystal_pin_in_gpio && crystal_pin_out_gpio && !high_speed_crystal_on
      && !low_speed_crystal_on) else $error("external clock pin mode inconsistent");
  idle_gate_a: assert property (
    wfi_exec && !deep_sleep_bit && !cpu_irq_pending && cpu_clk_en && sys_clk_en
      |=> !cpu_clk_en && sys_clk_en && periph_clk_en) else $error("idle entry gated wrong clocks");
  pd_gate_a: assert property (
    $fell(periph_clk_en) |-> !sys_clk_en && !cpu_clk_en && !high_speed_rc_on && !high_speed_crystal_on
      && low_speed_rc_on == $past(low_speed_rc_on) && wdt_clk_en == wdt_src_slow_rc)
    else $error("power-down gating wrong");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read accepted while answering");
  r_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  b_latency_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
endmodule // pdctl_asserts
bind power_down_oscillator_control pdctl_asserts pdctl_asserts_i (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .wfi_exec, .deep_sleep_bit, .cpu_irq_pending,
  .wdt_src_slow_rc, .cpu_clk_en, .sys_clk_en, .periph_clk_en, .wdt_clk_en, .flash_programmer_clock_enable,
  .low_speed_rc_on, .high_speed_rc_on, .high_speed_crystal_on, .low_speed_crystal_on,
  .crystal_pin_in_ext_clock, .crystal_pin_in_gpio, .crystal_pin_out_gpio, .wake_irq);

/* dv/power_down_oscillator_control_tb_top.sv */
// Self-checking bench: registers over AXI4-Lite, idle and power-down entry, wake delay.
// Assumes the design under rtl/ with the checker bound to it; one 100 MHz clock.
`timescale 1ns/1ps
module power_down_oscillator_control_tb_top;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, seed, tick_cnt, d;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [1:0]  sys_src_sel, r;
  logic        wfi_exec, deep_sleep_bit, cpu_irq_pending, wake_event_pin, src_tick, wdt_src_slow_rc, tick_on;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         cpu_clk_en, sys_clk_en, periph_clk_en, wdt_clk_en, flash_programmer_clock_enable;
  wire         low_speed_rc_on, high_speed_rc_on, high_speed_crystal_on, low_speed_crystal_on;
  wire         crystal_pin_in_ext_clock, crystal_pin_in_gpio, crystal_pin_out_gpio, wake_irq, irq;
  wire  [4:0]  pins = {high_speed_crystal_on, low_speed_crystal_on, crystal_pin_in_ext_clock, crystal_pin_in_gpio,
                       crystal_pin_out_gpio};
  int          mismatches, check_count, cycles, ticks;
  // Crystal delay shortened to 20 source ticks to keep the run short
  power_down_oscillator_control #(.DLY_XTAL_CYC(13'h14)) power_down_oscillator_control_i (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wfi_exec, .deep_sleep_bit,
    .cpu_irq_pending, .wake_event_pin, .sys_src_sel, .src_tick, .wdt_src_slow_rc, .cpu_clk_en, .sys_clk_en,
    .periph_clk_en, .wdt_clk_en, .flash_programmer_clock_enable, .low_speed_rc_on, .high_speed_rc_on,
    .high_speed_crystal_on, .low_speed_crystal_on, .crystal_pin_in_ext_clock, .crystal_pin_in_gpio,
    .crystal_pin_out_gpio, .wake_irq, .irq);
  // ************************************************************
  // Clock, source ticks, tick counting and timeout
  // ************************************************************
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Ticks every fourth cycle so the count seen at the clock release is exact
  always @(posedge aclk) begin
    tick_cnt <= aresetn ? tick_cnt + 32'h1 : 32'h0;
    src_tick <= tick_on && (tick_cnt[1:0] == 2'h0);
    if (!tick_on) ticks <= 0;
    else if (src_tick && !sys_clk_en) ticks <= ticks + 1;
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end
  // ************************************************************
  // Tasks and functions
  // ************************************************************
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Ready is sampled at the falling edge, where it is settled; release follows the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw, w, b;
    b = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ar, got;
    got = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      got = s_axi_rvalid;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (got) s_axi_rready <= 1'b0;
    end
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a, d, r);
    chk(nm, e, d & m);
    chk("read resp", 2'h0, r);
  endtask
  // Power-down entry, wake by pin, then count the source ticks of the held-off clock
  task automatic pd(input logic [1:0] sel, input logic dly, input logic wie, input logic wl, input int exp_t);
    logic [31:0] base;
    base = 32'h0C | (dly << 4) | (wie << 5);
    wr(8'h00, base, r);
    wr(8'h00, base | 32'h80, r);
    @(posedge aclk);
    sys_src_sel <= sel;
    wdt_src_slow_rc <= wl;
    deep_sleep_bit <= 1'b1;
    wfi_exec <= 1'b1;
    @(posedge aclk);
    wfi_exec <= 1'b0;
    repeat (3) @(negedge aclk);
    chk("pd gates", {4'h2, wl}, {sys_clk_en, periph_clk_en, low_speed_rc_on, high_speed_rc_on, wdt_clk_en});
    @(posedge aclk);
    wake_event_pin <= 1'b1;
    repeat (12) @(posedge aclk);
    wake_event_pin <= 1'b0;
    tick_on <= 1'b1;
    while (!sys_clk_en) @(negedge aclk);
    @(posedge aclk);
    tick_on <= 1'b0;
    deep_sleep_bit <= 1'b0;
    @(negedge aclk);
    chk("delay ticks", exp_t, ticks);
    rchk("pwr after wake", 8'h00, 32'h3FF, base | 32'h40);
    chk("wake irq", wie, wake_irq);
    wr(8'h00, base | 32'h40, r);
    rchk("wake flag cleared", 8'h00, 32'h3FF, base);
    chk("wake irq off", 0, wake_irq);
    rchk("wake event", 8'h08, 32'h1, 32'h1);
    wr(8'h08, 32'h7, r);
    $display("power-down test source %0d done", sel);
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {wfi_exec, deep_sleep_bit, cpu_irq_pending, wake_event_pin, tick_on} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot, sys_src_sel} = '0;
    s_axi_wstrb = 4'hF;
    wdt_src_slow_rc = 1'b1;
    seed = 32'h0280;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("pwr reset", 8'h00, 32'hFFFFFFFF, 32'h1C);
    rchk("busgate reset", 8'h04, 32'hFFFFFFFF, 32'h5);
    rd(8'h20, d, r);
    chk("hole data", 0, d);
    chk("hole resp", 2'h2, r);
    wr(8'h20, 32'h0, r);
    chk("hole wr resp", 2'h2, r);
    // Locked write refused; refusal event drives irq only when masked in
    wr(8'h00, 32'h3, r);
    chk("locked resp", 2'h0, r);
    rchk("pwr locked", 8'h00, 32'h3FF, 32'h1C);
    rchk("refused event", 8'h08, 32'h4, 32'h4);
    chk("irq masked", 0, irq);
    wr(8'h0C, 32'h4, r);
    @(negedge aclk);
    chk("irq raised", 1, irq);
    wr(8'h08, 32'h4, r);
    @(negedge aclk);
    chk("irq cleared", 0, irq);
    wr(8'h10, 32'h59, r);
    wr(8'h10, 32'h16, r);
    wr(8'h10, 32'h88, r);
    rchk("unlocked", 8'h10, 32'h1, 32'h1);
    $display("register test done");
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, 32'h1C | m, r);
      repeat (2) @(negedge aclk);
      chk("pin modes", {m == 1, m == 2, m == 3, m == 0, m == 0 || m == 3}, pins);
    end
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(8'h00, seed & 32'h23F, r);
      wr(8'h04, seed, r);
      rchk("pwr random", 8'h00, 32'h3FF, seed & 32'h23F);
      rchk("busgate random", 8'h04, 32'h4, seed & 32'h4);
      chk("rc enables", seed[3:2], {low_speed_rc_on, high_speed_rc_on});
      chk("flash clock", seed[2], flash_programmer_clock_enable);
    end
    $display("field test done");
    wr(8'h00, 32'h1C, r);
    // Idle with deep sleep off, then deep sleep on but power-down enable clear
    for (int k = 0; k < 2; k++) begin
      @(posedge aclk);
      deep_sleep_bit <= k[0];
      wfi_exec <= 1'b1;
      @(posedge aclk);
      wfi_exec <= 1'b0;
      @(negedge aclk);
      chk("idle gates", 3'h3, {cpu_clk_en, sys_clk_en, periph_clk_en});
      @(posedge aclk);
      cpu_irq_pending <= 1'b1;
      repeat (3) @(posedge aclk);
      cpu_irq_pending <= 1'b0;
      deep_sleep_bit <= 1'b0;
      @(negedge aclk);
      chk("idle exit", 1, cpu_clk_en);
    end
    $display("idle test done");
    pd(2'h0, 1'b1, 1'b1, 1'b1, 16);
    pd(2'h1, 1'b1, 1'b0, 1'b0, 20);
    pd(2'h2, 1'b0, 1'b1, 1'b1, 0);
    final_report();
  end
endmodule // power_down_oscillator_control_tb_top
